// ==== dv/ethernet_output_and_input2_config_tb_top.sv ====
// Self-checking bench for the Ethernet output and input-two config registers.
// Assumes eoc_pkg and eoc_regs are compiled first; the bench is the AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
module ethernet_output_and_input2_config_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cfg_chk = 1'b0, rd_dp = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp;
    eoc_pkg::eoc_cfg_t cfg;
    logic [31:0] q[$];
    logic [7:0] r20 = 8'h00, r21 = 8'h00;
    logic [15:0] seed = 16'h0032;
    int n_fail = 0, num_checks = 0;
    localparam logic [31:0] A_ETH = {22'h0, eoc_pkg::OFS_ETH_OUT, 2'h0};
    localparam logic [31:0] A_IN2 = {22'h0, eoc_pkg::OFS_IN2_MON, 2'h0};
    eoc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cfg(cfg));
    always #5 hclk = ~hclk;
    //==========================================================
    // Result monitor: read data phases and cfg probes
    always @(posedge hclk) begin
        rd_dp <= hsel && htrans == eoc_pkg::HTRANS_NONSEQ && !hwrite;
        if (rd_dp || cfg_chk) begin
            num_checks++;
            if ((rd_dp ? {hresp, hrdata} : {23'h0, cfg}) !== {1'b0, q.pop_front()}) begin
                n_fail++;
                $display("BAD %0t result mismatch", $time);
            end
        end
    end
    //==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic finish_test();
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= eoc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic chk_cfg();
        @(posedge hclk);
        q.push_back({22'h0, r20[7], ~r20[6], r20[5:0], r21[5:4]});
        cfg_chk <= 1'b1;
        @(posedge hclk);
        cfg_chk <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        q.push_back({24'h0, a == A_ETH ? r20 : a == A_IN2 ? r21 : 8'h00});
        xfer(1'b0, a, {seed, seed});
    endtask
    task automatic rd_all();
        rd(A_ETH);
        rd(A_IN2);
        rd(32'h40);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        if (a == A_ETH) r20 = d[7:0];
        if (a == A_IN2) r21 = d[7:0] & eoc_pkg::MSK_IN2_MON;
        chk_cfg();
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        r20 = 8'h00;
        r21 = 8'h00;
        chk_cfg();
        rd_all();
    endtask
    //==========================================================
    // Main sequence: walking bits, every bucket code, random traffic
    initial begin
        logic [31:0] a, d;
        @(posedge hclk);
        do_reset();
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            d = i < 8 ? 32'h1 << i : {seed, seed};
            if (i >= 8 && i < 12) d[5:4] = i[1:0];
            a = i < 8 ? A_ETH : i < 12 ? A_IN2 : (seed[9:8] == 2'h0 ? 32'h40 : (seed[8] ? A_IN2 : A_ETH));
            wr(a, d);
            rd_all();
            if (i == 15) do_reset();
        end
        finish_test();
    end
    initial begin
        #20000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire

// ==== rtl/eoc_pkg.sv ====
// Constants, register map and carrier types for the Ethernet output config bank.
// Assumes a single AHB-Lite master on hclk.
//==========================================================
// Behaviour
// (RULE1) Top bit of output register enables 2 kHz sync alignment of Ethernet clocks.
// (RULE2) Bit six low keeps the Ethernet frequency loop enabled; high disables it.
// (RULE3) Bits one and zero pick Ethernet frequency for outputs two and one.
// (RULE4) Bits three and two pick Ethernet frequency for outputs four and three.
// (RULE5) Bits five and four pick Ethernet frequency for outputs six and five.
// (RULE6) Every input channel owns a leaky-bucket accumulator for activity judgement; this bank only holds the bucket choice for input two.
// (RULE7) Bits five to four choose bucket configuration zero to three for input two.
// (RULE8) Output register resets to zero: non-Ethernet, no alignment, loop enabled.
// (RULE9) Software writes zero to unused input-two bits and expects zero.
package eoc_pkg;
    localparam int unsigned REG_W = 8;
    localparam int unsigned OUT_N = 6;
    // Register offsets are word indices; the byte address is four times the index
    localparam int unsigned IDX_LO = 2;
    localparam logic [7:0] OFS_ETH_OUT = 8'h20;
    localparam logic [7:0] OFS_IN2_MON = 8'h21;
    localparam logic [7:0] RST_ETH_OUT = 8'h00;
    localparam logic [7:0] RST_IN2_MON = 8'h00;
    localparam int unsigned BIT_SYNC_ALIGN = 7;
    localparam int unsigned BIT_LOOP_DIS = 6;
    localparam int unsigned FLD_LEAK_LO = 4;
    localparam logic [7:0] MSK_IN2_MON = 8'h30;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic ethernet_sync_align_on;
        logic ethernet_loop_on;
        logic [5:0] out_ethernet_sel;
        logic [1:0] input_two_leak_cfg_sel;
    } eoc_cfg_t;
endpackage

// ==== rtl/eoc_regs.sv ====
// AHB-Lite slave holding the Ethernet output and input-two monitor registers.
// Assumes one master; zero wait states, response always OKAY.
`timescale 1ns/1ns
`default_nettype none
module eoc_regs #(
    parameter int unsigned ADDR_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output eoc_pkg::eoc_cfg_t cfg
);
    //==========================================================
    // Elaboration check
    if (ADDR_W < eoc_pkg::IDX_LO + eoc_pkg::REG_W) begin : g_addr_w_check
        $error("ADDR_W too small for the register word index");
    end

    //==========================================================
    // Address phase capture
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [7:0] eth_out_reg;
    logic [7:0] in2_mon_reg;
    logic acc;
    logic [7:0] ofs;
    logic [31:0] rd_next;

    assign acc = hsel && hready && (htrans == eoc_pkg::HTRANS_NONSEQ || htrans == eoc_pkg::HTRANS_SEQ);
    // Word index taken from the byte address
    assign ofs = haddr[eoc_pkg::IDX_LO +: eoc_pkg::REG_W];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
        end else begin
            wr_pend_reg <= acc && hwrite;
            wr_ofs_reg <= ofs;
        end
    end

    //==========================================================
    // Register storage
    // (RULE8) Output register cleared at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eth_out_reg <= eoc_pkg::RST_ETH_OUT;
        end else if (wr_pend_reg && wr_ofs_reg == eoc_pkg::OFS_ETH_OUT) begin
            eth_out_reg <= hwdata[7:0];
        end
    end

    // (RULE9) Unused input-two bits held zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in2_mon_reg <= eoc_pkg::RST_IN2_MON;
        end else if (wr_pend_reg && wr_ofs_reg == eoc_pkg::OFS_IN2_MON) begin
            in2_mon_reg <= hwdata[7:0] & eoc_pkg::MSK_IN2_MON;
        end
    end

    //==========================================================
    // Read data, registered for the data phase
    always_comb begin
        rd_next = 32'h0000_0000;
        if (acc && !hwrite) begin
            if (ofs == eoc_pkg::OFS_ETH_OUT) begin
                rd_next = {24'h00_0000, eth_out_reg};
            end else if (ofs == eoc_pkg::OFS_IN2_MON) begin
                rd_next = {24'h00_0000, in2_mon_reg};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= rd_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    //==========================================================
    // Configuration outputs, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= '0;
            cfg.ethernet_loop_on <= 1'b1;
        end else begin
            // (RULE1) Sync alignment enable
            cfg.ethernet_sync_align_on <= eth_out_reg[eoc_pkg::BIT_SYNC_ALIGN];
            // (RULE2) Loop enable is active low
            cfg.ethernet_loop_on <= ~eth_out_reg[eoc_pkg::BIT_LOOP_DIS];
            // (RULE3) (RULE4) (RULE5) Per-output Ethernet select
            cfg.out_ethernet_sel <= eth_out_reg[eoc_pkg::OUT_N-1:0];
            // (RULE6) (RULE7) Bucket choice for input two's accumulator
            cfg.input_two_leak_cfg_sel <= in2_mon_reg[eoc_pkg::FLD_LEAK_LO +: 2];
        end
    end

    //==========================================================
    // Check helpers
    logic wr_eth;
    logic wr_in2;
    logic rd_any;
    logic rd_eth;
    logic rd_in2;

    assign wr_eth = wr_pend_reg && wr_ofs_reg == eoc_pkg::OFS_ETH_OUT;
    assign wr_in2 = wr_pend_reg && wr_ofs_reg == eoc_pkg::OFS_IN2_MON;
    assign rd_any = acc && !hwrite;
    assign rd_eth = rd_any && ofs == eoc_pkg::OFS_ETH_OUT;
    assign rd_in2 = rd_any && ofs == eoc_pkg::OFS_IN2_MON;

    //==========================================================
    // Checks: bus response

    ready_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout == 1'b1)
        else $error("slave inserted a wait state");

    resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == 1'b0)
        else $error("slave answered with an error response");

    rd_upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hrdata[31:eoc_pkg::REG_W] == '0)
        else $error("read data upper bits not zero");

    //==========================================================
    // Checks: address phase capture

    wr_pend_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (acc && hwrite) |=> wr_pend_reg)
        else $error("accepted write not pending");

    wr_pend_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(acc && hwrite) |=> !wr_pend_reg)
        else $error("write pending without an accepted write");

    wr_ofs_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc |=> wr_ofs_reg == $past(ofs))
        else $error("write index not captured");

    //==========================================================
    // Checks: register writes

    wr_eth_land_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_eth |=> eth_out_reg == $past(hwdata[eoc_pkg::REG_W-1:0]))
        else $error("output register write did not land");

    wr_in2_land_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        wr_in2 |=> in2_mon_reg == ($past(hwdata[eoc_pkg::REG_W-1:0]) & eoc_pkg::MSK_IN2_MON))
        else $error("input two register write did not land");

    eth_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_eth |=> $stable(eth_out_reg))
        else $error("output register changed without write");

    leak_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
        !wr_in2 |=> $stable(in2_mon_reg))
        else $error("bucket choice changed without write");

    unmapped_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && !wr_eth && !wr_in2) |=> $stable(eth_out_reg) && $stable(in2_mon_reg))
        else $error("unmapped write changed a register");

    unused_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        (in2_mon_reg & ~eoc_pkg::MSK_IN2_MON) == 8'h00)
        else $error("unused input two bits set");

    //==========================================================
    // Checks: read data

    rd_eth_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_eth |=> hrdata[eoc_pkg::REG_W-1:0] == $past(eth_out_reg))
        else $error("output register read wrong");

    rd_in2_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        rd_in2 |=> hrdata[eoc_pkg::REG_W-1:0] == $past(in2_mon_reg))
        else $error("input two register read wrong");

    rd_idle_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(rd_eth || rd_in2) |=> hrdata == 32'h0000_0000)
        else $error("read data not zero outside a mapped read");

    //==========================================================
    // Checks: configuration outputs

    sync_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        1'b1 |=> cfg.ethernet_sync_align_on == $past(eth_out_reg[eoc_pkg::BIT_SYNC_ALIGN]))
        else $error("sync align not following its bit");

    loop_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        1'b1 |=> cfg.ethernet_loop_on != $past(eth_out_reg[eoc_pkg::BIT_LOOP_DIS]))
        else $error("loop enable polarity wrong");

    out_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        1'b1 |=> cfg.out_ethernet_sel[1:0] == $past(eth_out_reg[1:0]))
        else $error("outputs one two select wrong");

    leak_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        1'b1 |=> cfg.input_two_leak_cfg_sel == $past(in2_mon_reg[eoc_pkg::FLD_LEAK_LO +: 2]))
        else $error("bucket select not following register");

    // Per output select, one pair of checks for each bit
    for (genvar k = 0; k < eoc_pkg::OUT_N; k++) begin : g_sel_chk
        sel_bit_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3 RULE4 RULE5
            1'b1 |=> cfg.out_ethernet_sel[k] == $past(eth_out_reg[k]))
            else $error("output select bit not following register");

        sel_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3 RULE4 RULE5
            wr_eth |=> ##1 cfg.out_ethernet_sel[k] == $past(hwdata[k], 2))
            else $error("output select bit not following write");
    end

    //==========================================================
    // Checks: end to end from a bus write

    sync_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        wr_eth |=> ##1 cfg.ethernet_sync_align_on == $past(hwdata[eoc_pkg::BIT_SYNC_ALIGN], 2))
        else $error("sync align not following write");

    loop_wr_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        wr_eth |=> ##1 cfg.ethernet_loop_on != $past(hwdata[eoc_pkg::BIT_LOOP_DIS], 2))
        else $error("loop enable not following write");

    out_one_two_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        wr_eth |=> ##1 cfg.out_ethernet_sel[1:0] == $past(hwdata[1:0], 2))
        else $error("outputs one two not following write");

    out_mid_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
        wr_eth |=> ##1 cfg.out_ethernet_sel[3:2] == $past(hwdata[3:2], 2))
        else $error("outputs three four select wrong");

    out_high_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
        wr_eth |=> ##1 cfg.out_ethernet_sel[5:4] == $past(hwdata[5:4], 2))
        else $error("outputs five six select wrong");

    leak_sel_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        wr_in2 |=> ##1 cfg.input_two_leak_cfg_sel == $past(hwdata[5:4], 2))
        else $error("input two bucket select wrong");

    //==========================================================
    // Checks: values after reset

    reset_zero_a: assert property (@(posedge hclk) // RULE8
        $rose(hresetn) |-> eth_out_reg == eoc_pkg::RST_ETH_OUT)
        else $error("output register not zero after reset");

    in2_reset_a: assert property (@(posedge hclk) // RULE9
        $rose(hresetn) |-> in2_mon_reg == eoc_pkg::RST_IN2_MON)
        else $error("input two register not zero after reset");

    cfg_reset_a: assert property (@(posedge hclk) // RULE8
        $rose(hresetn) |-> cfg.ethernet_loop_on && !cfg.ethernet_sync_align_on
            && cfg.out_ethernet_sel == '0 && cfg.input_two_leak_cfg_sel == '0)
        else $error("configuration outputs wrong after reset");

    rd_reset_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> hrdata == 32'h0000_0000 && hreadyout && !hresp)
        else $error("bus outputs wrong after reset");
endmodule
`default_nettype wire
